// ### logic/cmrb_bank.sv
// Mixer and extended-audio control register bank.
// Assumes a front end presents one-cycle word requests on the core clock;
// serial byte access is folded into words by the byte port below.
`timescale 1ns/1ps
`default_nettype none

module cmrb_bank (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire cmrb_pkg::cmrb_req_s req,
  input  wire logic               byte_wr,
  input  wire logic               byte_rd,
  input  wire logic [7:0]         byte_addr,
  input  wire logic [7:0]         byte_wdata,
  input  wire logic               codec_select_pin,
  output logic [15:0]             rdata,
  output logic                    rvalid,
  output logic [7:0]              byte_rdata,
  output logic                    byte_rvalid,
  output cmrb_pkg::cmrb_chan_s    left_atten,
  output cmrb_pkg::cmrb_chan_s    right_atten,
  output cmrb_pkg::cmrb_chan_s    sub_atten,
  output cmrb_pkg::cmrb_chan_s    centre_atten,
  output cmrb_pkg::cmrb_chan_s    left_rear_atten,
  output cmrb_pkg::cmrb_chan_s    right_rear_atten,
  output cmrb_pkg::cmrb_tone_s    front_tone,
  output logic                    link_quiesce,
  output logic                    core_sleep_request,
  output logic                    amp_shutdown_request,
  output logic                    variable_rate_en,
  output logic                    double_rate_en,
  output logic [16:0]             effective_rate,
  output logic                    full_compliance_select
);

  logic        rst_meta_q;
  logic        rst_sync_q;
  logic        sel_meta_q;
  logic        sel_sync_q;

  logic [15:0] front_vol_q;
  logic [15:0] tone_q;
  logic [15:0] pwr_q;
  logic [15:0] ext_ctrl_q;
  logic [15:0] front_rate_q;
  logic [15:0] lfec_vol_q;
  logic [15:0] rear_vol_q;
  logic [15:0] vendor_q;
  logic [7:0]  hi_byte_q;

  logic        wr;
  logic        rd;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic        soft_reset;
  logic [15:0] ext_id;
  logic [15:0] word_read;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      sel_meta_q <= codec_select_pin;
      sel_sync_q <= sel_meta_q;
    end
  end

  // Even byte is held until its odd partner arrives, so a word updates atomically
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hi_byte_q <= 8'h00;
    end else if (byte_wr && !byte_addr[0] && !byte_addr[7]) begin
      hi_byte_q <= byte_wdata;
    end
  end

  always_comb begin
    wr    = req.wr;
    rd    = req.rd;
    addr  = req.addr;
    wdata = req.wdata;
    // Any byte strobe pre-empts the word port; byte addresses above 7Fh map to nothing
    if (byte_wr || byte_rd) begin
      wr    = byte_wr && byte_addr[0] && !byte_addr[7];
      rd    = 1'b0;
      addr  = {byte_addr[6:1], 1'b0};
      wdata = {hi_byte_q, byte_wdata};
    end
  end

  assign soft_reset = wr && (addr == cmrb_pkg::OFS_RESET);

  function automatic logic is_wr(input logic w, input logic [6:0] a, input logic [6:0] o);
    is_wr = w && (a == o);
  endfunction

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      front_vol_q <= cmrb_pkg::RST_FRONT_VOL;
    end else if (soft_reset) begin
      front_vol_q <= cmrb_pkg::RST_FRONT_VOL;
    end else if (is_wr(wr, addr, cmrb_pkg::OFS_FRONT_VOL)) begin
      front_vol_q <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tone_q <= cmrb_pkg::RST_TONE;
    end else if (soft_reset) begin
      tone_q <= cmrb_pkg::RST_TONE;
    end else if (is_wr(wr, addr, cmrb_pkg::OFS_TONE)) begin
      tone_q <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pwr_q <= cmrb_pkg::RST_PWR;
    end else if (soft_reset) begin
      pwr_q <= cmrb_pkg::RST_PWR;
    end else if (is_wr(wr, addr, cmrb_pkg::OFS_PWR)) begin
      pwr_q <= {wdata[15:4], cmrb_pkg::PWR_FIXED};
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ext_ctrl_q <= cmrb_pkg::RST_EXT_CTRL;
    end else if (soft_reset) begin
      ext_ctrl_q <= cmrb_pkg::RST_EXT_CTRL;
    end else if (is_wr(wr, addr, cmrb_pkg::OFS_EXT_CTRL)) begin
      ext_ctrl_q <= {wdata[15:10], cmrb_pkg::EXT_READY, wdata[5:0]};
    end
  end

  // Only the two supported rates are ever stored; the copies share this register
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      front_rate_q <= cmrb_pkg::RST_RATE;
    end else if (soft_reset) begin
      front_rate_q <= cmrb_pkg::RST_RATE;
    end else if (is_wr(wr, addr, cmrb_pkg::OFS_FRONT_RATE)) begin
      if (wdata < cmrb_pkg::RATE_MID) begin
        front_rate_q <= cmrb_pkg::RATE_44K1;
      end else begin
        front_rate_q <= cmrb_pkg::RST_RATE;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      lfec_vol_q <= cmrb_pkg::RST_MC_VOL;
      rear_vol_q <= cmrb_pkg::RST_MC_VOL;
    end else if (soft_reset) begin
      lfec_vol_q <= cmrb_pkg::RST_MC_VOL;
      rear_vol_q <= cmrb_pkg::RST_MC_VOL;
    end else begin
      if (is_wr(wr, addr, cmrb_pkg::OFS_LFEC_VOL)) begin
        lfec_vol_q <= wdata;
      end
      if (is_wr(wr, addr, cmrb_pkg::OFS_REAR_VOL)) begin
        rear_vol_q <= wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      vendor_q <= cmrb_pkg::RST_VENDOR_A;
    end else if (soft_reset) begin
      vendor_q <= cmrb_pkg::RST_VENDOR_A;
    end else if (is_wr(wr, addr, cmrb_pkg::OFS_VENDOR_A)) begin
      vendor_q <= wdata;
    end
  end

  always_comb begin
    ext_id = cmrb_pkg::EXT_ID_BASE;
    ext_id[cmrb_pkg::EXT_ID_IDX_BIT] = sel_sync_q;
  end

  always_comb begin
    case (addr)
      cmrb_pkg::OFS_RESET:      word_read = cmrb_pkg::ID_CODE;
      cmrb_pkg::OFS_FRONT_VOL:  word_read = front_vol_q;
      cmrb_pkg::OFS_TONE:       word_read = tone_q;
      cmrb_pkg::OFS_PWR:        word_read = pwr_q;
      cmrb_pkg::OFS_EXT_ID:     word_read = ext_id;
      cmrb_pkg::OFS_EXT_CTRL:   word_read = ext_ctrl_q;
      cmrb_pkg::OFS_FRONT_RATE: word_read = front_rate_q;
      cmrb_pkg::OFS_SURR_RATE:  word_read = front_rate_q;
      cmrb_pkg::OFS_LFEC_RATE:  word_read = front_rate_q;
      cmrb_pkg::OFS_IN_RATE_A:  word_read = cmrb_pkg::RST_RATE;
      cmrb_pkg::OFS_IN_RATE_B:  word_read = cmrb_pkg::RST_RATE;
      cmrb_pkg::OFS_LFEC_VOL:   word_read = lfec_vol_q;
      cmrb_pkg::OFS_REAR_VOL:   word_read = rear_vol_q;
      cmrb_pkg::OFS_VENDOR_A:   word_read = vendor_q;
      default:                  word_read = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata       <= 16'h0000;
      rvalid      <= 1'b0;
      byte_rdata  <= 8'h00;
      byte_rvalid <= 1'b0;
    end else begin
      rvalid      <= rd;
      rdata       <= rd ? word_read : 16'h0000;
      byte_rvalid <= byte_rd;
      byte_rdata  <= byte_addr[7] ? 8'h00
                   : (byte_addr[0] ? word_read[7:0] : word_read[15:8]);
    end
  end

  // Level to half-dB attenuation; proprietary codes are taken as 1 dB steps
  function automatic logic [7:0] level_atten(input logic mute, input logic [6:0] code,
                                             input logic fc_mode);
    logic [7:0] a;
    a = 8'h00;
    if (mute) begin
      a = cmrb_pkg::ATTEN_INF;
    end else if (fc_mode) begin
      a = {1'b0, code[5:0], 1'b0} + {2'b00, code[5:0]};
    end else if (code >= cmrb_pkg::LEVEL_MAX_PROP) begin
      a = cmrb_pkg::ATTEN_INF;
    end else begin
      a = {code, 1'b0};
    end
    level_atten = a;
  endfunction

  logic fc_mode;
  assign fc_mode = !vendor_q[cmrb_pkg::FC_BIT];

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      left_atten       <= '0;
      right_atten      <= '0;
      sub_atten        <= '0;
      centre_atten     <= '0;
      left_rear_atten  <= '0;
      right_rear_atten <= '0;
    end else begin
      left_atten.atten  <= level_atten(front_vol_q[15], front_vol_q[14:8], fc_mode);
      right_atten.atten <= level_atten(front_vol_q[15], front_vol_q[6:0], fc_mode);
      sub_atten.atten    <= level_atten(lfec_vol_q[15], lfec_vol_q[14:8], fc_mode);
      centre_atten.atten <= level_atten(lfec_vol_q[7], lfec_vol_q[6:0], fc_mode);
      left_rear_atten.atten  <= level_atten(rear_vol_q[15], rear_vol_q[14:8], fc_mode);
      right_rear_atten.atten <= level_atten(rear_vol_q[7], rear_vol_q[6:0], fc_mode);
    end
  end

  // Only the front pair receives tone settings; the DSP shelves sit at fixed centres
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      front_tone <= '0;
    end else begin
      front_tone.bass_on <= (tone_q[11:8] != cmrb_pkg::TONE_BYPASS);
      front_tone.bass    <= tone_q[11:8];
      front_tone.treb_on <= (tone_q[3:0] != cmrb_pkg::TONE_BYPASS);
      front_tone.treb    <= tone_q[3:0];
    end
  end

  // Sticky: clearing bit 12 again does not wake the link, only a hardware or soft reset
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      link_quiesce <= 1'b0;
    end else if (soft_reset) begin
      link_quiesce <= 1'b0;
    end else if (pwr_q[cmrb_pkg::PWR_QUIESCE]) begin
      link_quiesce <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      core_sleep_request     <= 1'b0;
      amp_shutdown_request   <= 1'b0;
      variable_rate_en       <= 1'b0;
      double_rate_en         <= 1'b0;
      effective_rate         <= 17'h00000;
      full_compliance_select <= 1'b0;
    end else begin
      core_sleep_request     <= pwr_q[cmrb_pkg::PWR_SLEEP];
      amp_shutdown_request   <= pwr_q[cmrb_pkg::PWR_AMP];
      variable_rate_en       <= ext_ctrl_q[cmrb_pkg::EXT_VRA];
      double_rate_en         <= ext_ctrl_q[cmrb_pkg::EXT_DRA];
      effective_rate         <= ext_ctrl_q[cmrb_pkg::EXT_DRA] ? {front_rate_q, 1'b0}
                                                              : {1'b0, front_rate_q};
      full_compliance_select <= fc_mode;
    end
  end

endmodule

`default_nettype wire

// ### logic/cmrb_pkg.sv
// Package for the mixer register bank: offsets, reset values, field layouts.
// Assumes a 16-bit register port driven by a link or serial-control front end.
`default_nettype none
package cmrb_pkg;

  localparam logic [6:0]  OFS_RESET      = 7'h00;
  localparam logic [6:0]  OFS_FRONT_VOL  = 7'h02;
  localparam logic [6:0]  OFS_TONE       = 7'h08;
  localparam logic [6:0]  OFS_PWR        = 7'h26;
  localparam logic [6:0]  OFS_EXT_ID     = 7'h28;
  localparam logic [6:0]  OFS_EXT_CTRL   = 7'h2a;
  localparam logic [6:0]  OFS_FRONT_RATE = 7'h2c;
  localparam logic [6:0]  OFS_SURR_RATE  = 7'h2e;
  localparam logic [6:0]  OFS_LFEC_RATE  = 7'h30;
  localparam logic [6:0]  OFS_IN_RATE_A  = 7'h32;
  localparam logic [6:0]  OFS_IN_RATE_B  = 7'h34;
  localparam logic [6:0]  OFS_LFEC_VOL   = 7'h36;
  localparam logic [6:0]  OFS_REAR_VOL   = 7'h38;
  localparam logic [6:0]  OFS_VENDOR_A   = 7'h5a;

  localparam logic [15:0] RST_FRONT_VOL  = 16'h8000;
  localparam logic [15:0] RST_TONE       = 16'h0f0f;
  localparam logic [15:0] RST_PWR        = 16'h800e;
  localparam logic [15:0] RST_EXT_CTRL   = 16'h01c0;
  localparam logic [15:0] RST_RATE       = 16'hbb80;
  localparam logic [15:0] RST_MC_VOL     = 16'h8080;
  localparam logic [15:0] RST_VENDOR_A   = 16'h0000;
  localparam logic [15:0] RATE_44K1      = 16'hac44;
  // Midpoint of the two rates; a tie resolves to the higher rate
  localparam logic [15:0] RATE_MID       = 16'hb3e2;

  // Arbitrary identification value, not tied to any real part
  localparam logic [15:0] ID_CODE        = 16'h0a5c;
  localparam logic [15:0] EXT_ID_BASE    = 16'h01c3;
  localparam int          EXT_ID_IDX_BIT = 14;

  localparam logic [3:0]  PWR_FIXED      = 4'he;
  localparam logic [3:0]  EXT_READY      = 4'h7;
  localparam int          PWR_QUIESCE    = 12;
  localparam int          PWR_SLEEP      = 13;
  localparam int          PWR_AMP        = 15;
  localparam int          EXT_VRA        = 0;
  localparam int          EXT_DRA        = 1;
  localparam int          EXT_RDY_LO     = 6;
  localparam int          VOL_MUTE_HI    = 15;
  localparam int          VOL_MUTE_LO    = 7;
  localparam int          FC_BIT         = 0;

  localparam logic [6:0]  LEVEL_MAX_PROP = 7'h68;
  localparam logic [7:0]  ATTEN_INF      = 8'hff;
  localparam logic [3:0]  TONE_BYPASS    = 4'hf;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } cmrb_req_s;

  // One channel's decoded setting: attenuation in half-dB steps, 8'hff is silence
  typedef struct packed {
    logic [7:0] atten;
  } cmrb_chan_s;

  typedef struct packed {
    logic       bass_on;
    logic [3:0] bass;
    logic       treb_on;
    logic [3:0] treb;
  } cmrb_tone_s;

endpackage

`default_nettype wire

// ### tb/cmrb_bank_sva.sv
// Checker for the mixer register bank, bound to cmrb_bank.
// Assumes one clock; cycles where a byte strobe wins are not treated as word requests.
`timescale 1ns/1ps
`default_nettype none
module cmrb_sva (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire cmrb_pkg::cmrb_req_s  req,
  input wire logic                 byte_wr,
  input wire logic                 byte_rd,
  input wire logic [15:0]          rdata,
  input wire logic                 rvalid,
  input wire cmrb_pkg::cmrb_chan_s left_atten,
  input wire cmrb_pkg::cmrb_chan_s right_atten,
  input wire logic                 link_quiesce,
  input wire logic                 amp_shutdown_request,
  input wire logic                 double_rate_en,
  input wire logic [16:0]          effective_rate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = req.wr && !byte_wr && !byte_rd;
  assign rd_ok = req.rd && !byte_wr && !byte_rd;

  property p_mute;
    wr_ok && req.addr == 7'h02 && req.wdata[15] |-> ##2 left_atten.atten == 8'hff
      && right_atten.atten == 8'hff;
  endproperty
  a_mute: assert property (p_mute) else $error("front mute not silent");
  property p_pwr;
    rd_ok && req.addr == 7'h26 |=> rvalid && rdata[3:0] == 4'he;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power low bits wrong");
  property p_extid;
    rd_ok && req.addr == 7'h28 |=> rvalid && !rdata[15] && rdata[13:0] == 14'h01c3;
  endproperty
  a_extid: assert property (p_extid) else $error("feature id wrong");
  property p_rdy;
    rd_ok && req.addr == 7'h2a |=> rvalid && rdata[9:6] == 4'h7;
  endproperty
  a_rdy: assert property (p_rdy) else $error("readiness bits wrong");
  property p_inrate;
    rd_ok && (req.addr == 7'h32 || req.addr == 7'h34) |=> rvalid && rdata == 16'hbb80;
  endproperty
  a_inrate: assert property (p_inrate) else $error("input rate not fixed");
  property p_snap;
    wr_ok && req.addr == 7'h2c && !double_rate_en |-> ##2
      effective_rate == (($past(req.wdata, 2) < 16'hb3e2) ? 17'h0ac44 : 17'h0bb80);
  endproperty
  a_snap: assert property (p_snap) else $error("rate not snapped");
  property p_dbl;
    rd_ok && req.addr == 7'h2c && double_rate_en |=> rvalid && effective_rate == {rdata, 1'b0};
  endproperty
  a_dbl: assert property (p_dbl) else $error("rate not doubled");
  property p_quiesce;
    wr_ok && req.addr == 7'h26 && req.wdata[12] |-> ##2 link_quiesce;
  endproperty
  a_quiesce: assert property (p_quiesce) else $error("link not quiesced");
  property p_quiesce_hold;
    link_quiesce && !(wr_ok && req.addr == 7'h00) && !byte_wr |=> link_quiesce;
  endproperty
  a_quiesce_hold: assert property (p_quiesce_hold) else $error("link woke early");
  property p_soft;
    wr_ok && req.addr == 7'h00 |-> ##2 amp_shutdown_request && left_atten.atten == 8'hff;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset incomplete");

  c_pwr: cover property (wr_ok && req.addr == 7'h26);
  c_dbl: cover property (rd_ok && req.addr == 7'h2c && double_rate_en);
  c_byte: cover property (byte_wr);
endmodule
`default_nettype wire

// ### tb/cmrb_host.sv
// Host model: drives word and byte register requests into the bank.
// Assumes answers are registered on the taking edge itself and are read 1 ns after it.
`timescale 1ns/1ps
`default_nettype none
module cmrb_host (
  input  wire logic                clock,
  input  wire logic [15:0]         rdata,
  input  wire logic                rvalid,
  input  wire logic [7:0]          byte_rdata,
  input  wire logic                byte_rvalid,
  output var cmrb_pkg::cmrb_req_s  req,
  output logic                     byte_wr,
  output logic                     byte_rd,
  output logic [7:0]               byte_addr,
  output logic [7:0]               byte_wdata
);
  initial begin
    req = '0;
    byte_wr = 1'b0;
    byte_rd = 1'b0;
    byte_addr = 8'h00;
    byte_wdata = 8'h00;
  end

  // Idle fields carry inverted values so nothing relies on stale address or data
  task automatic word(input logic w, input logic [6:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge clock);
    #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    #1 q = (rvalid === 1'b1) ? rdata : 'x;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic bytes(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clock);
    #1 byte_wr = w;
    byte_rd = !w;
    byte_addr = a;
    byte_wdata = d;
    @(posedge clock);
    #1 q = (byte_rvalid === 1'b1) ? byte_rdata : 'x;
    byte_wr = 1'b0;
    byte_rd = 1'b0;
    byte_addr = ~a;
    byte_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Top testbench for the mixer register bank with host model and checker.
// Assumes a 250 MHz core clock and one word or byte request at a time.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  logic                 codec_select_pin = 1'b0;
  cmrb_pkg::cmrb_req_s  req;
  logic                 byte_wr, byte_rd, rvalid, byte_rvalid;
  logic [7:0]           byte_addr, byte_wdata, byte_rdata;
  logic [15:0]          rdata;
  cmrb_pkg::cmrb_chan_s left_atten, right_atten, sub_atten, centre_atten;
  cmrb_pkg::cmrb_chan_s left_rear_atten, right_rear_atten;
  cmrb_pkg::cmrb_tone_s front_tone;
  logic                 link_quiesce, core_sleep_request, amp_shutdown_request;
  logic                 variable_rate_en, double_rate_en, full_compliance_select;
  logic [16:0]          effective_rate;
  int                   n_fail = 0;
  int                   checks_done = 0;
  int                   cycles = 0;

  cmrb_bank i_dut (.clock, .rstn, .req, .byte_wr, .byte_rd, .byte_addr, .byte_wdata,
    .codec_select_pin, .rdata, .rvalid, .byte_rdata, .byte_rvalid, .left_atten,
    .right_atten, .sub_atten, .centre_atten, .left_rear_atten, .right_rear_atten,
    .front_tone, .link_quiesce, .core_sleep_request, .amp_shutdown_request,
    .variable_rate_en, .double_rate_en, .effective_rate, .full_compliance_select);
  cmrb_host i_host (.clock, .rdata, .rvalid, .byte_rdata, .byte_rvalid, .req, .byte_wr,
    .byte_rd, .byte_addr, .byte_wdata);

  always #2 clock = ~clock;

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    i_host.word(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] q;
    i_host.word(1'b0, a, 16'h0000, q);
    chk({1'b0, q}, {1'b0, e});
  endtask

  // Derived outputs lag a register write by one cycle
  task automatic settle();
    @(posedge clock);
    #1;
  endtask

  task automatic t_defaults();
    rc(7'h00, cmrb_pkg::ID_CODE);
    rc(7'h02, 16'h8000);
    rc(7'h08, 16'h0f0f);
    rc(7'h26, 16'h800e);
    rc(7'h2a, 16'h01c0);
    for (int i = 0; i < 5; i++) rc(7'h2c + 7'(2 * i), 16'hbb80);
    rc(7'h36, 16'h8080);
    rc(7'h38, 16'h8080);
    rc(7'h5a, 16'h0000);
    rc(7'h10, 16'h0000);
    chk({15'h0, amp_shutdown_request, link_quiesce}, 17'h2);
    chk({16'h0, full_compliance_select}, 17'h1);
    chk({9'h0, left_atten.atten}, 17'hff);
  endtask

  task automatic t_volume();
    wr(7'h02, 16'h1f7f);
    settle();
    chk({9'h0, left_atten.atten}, 17'h5d);
    chk({9'h0, right_atten.atten}, 17'hbd);
    wr(7'h02, 16'h9f1f);
    settle();
    chk({1'b0, left_atten.atten, right_atten.atten}, 17'hffff);
    wr(7'h5a, 16'h0001);
    wr(7'h02, 16'h1f67);
    settle();
    chk({16'h0, full_compliance_select}, 17'h0);
    chk({1'b0, left_atten.atten, right_atten.atten}, 17'h3ece);
    wr(7'h02, 16'h0068);
    settle();
    chk({1'b0, left_atten.atten, right_atten.atten}, 17'h00ff);
    wr(7'h5a, 16'h0000);
  endtask

  task automatic t_tone();
    for (int c = 0; c < 16; c++) begin
      wr(7'h08, {4'h0, 4'(c), 4'h0, 4'(15 - c)});
      settle();
      chk({7'h0, front_tone}, {7'h0, c != 15, 4'(c), c != 0, 4'(15 - c)});
    end
  endtask

  task automatic t_power();
    wr(7'h26, 16'hb001);
    rc(7'h26, 16'hb00e);
    chk({14'h0, link_quiesce, core_sleep_request, amp_shutdown_request}, 17'h7);
    wr(7'h26, 16'h0000);
    rc(7'h26, 16'h000e);
    chk({15'h0, link_quiesce, amp_shutdown_request}, 17'h2);
  endtask

  task automatic t_ext();
    wr(7'h2a, 16'h0003);
    rc(7'h2a, 16'h01c3);
    chk({15'h0, variable_rate_en, double_rate_en}, 17'h3);
    wr(7'h2a, 16'h0000);
    rc(7'h2a, 16'h01c0);
    wr(7'h28, 16'hffff);
    rc(7'h28, 16'h01c3);
    codec_select_pin = 1'b1;
    repeat (3) settle();
    rc(7'h28, 16'h41c3);
  endtask

  task automatic t_rate();
    logic [15:0] wv [6] = '{16'hbb80, 16'hac44, 16'hb3e2, 16'hb3e1, 16'h0000, 16'hffff};
    logic [15:0] ev [6] = '{16'hbb80, 16'hac44, 16'hbb80, 16'hac44, 16'hac44, 16'hbb80};
    for (int i = 0; i < 6; i++) begin
      wr(7'h2c, wv[i]);
      rc(7'h2c, ev[i]);
      rc(7'h2e, ev[i]);
      rc(7'h30, ev[i]);
      chk(effective_rate, {1'b0, ev[i]});
    end
    wr(7'h32, 16'h1234);
    rc(7'h32, 16'hbb80);
    wr(7'h34, 16'h1234);
    rc(7'h34, 16'hbb80);
    wr(7'h2c, 16'hac44);
    wr(7'h2a, 16'h0002);
    rc(7'h2c, 16'hac44);
    chk(effective_rate, 17'h15888);
    wr(7'h2a, 16'h0000);
  endtask

  task automatic t_multi();
    wr(7'h36, 16'h0a85);
    wr(7'h38, 16'h8005);
    settle();
    chk({1'b0, sub_atten.atten, centre_atten.atten}, 17'h1eff);
    chk({1'b0, left_rear_atten.atten, right_rear_atten.atten}, 17'hff0f);
  endtask

  task automatic t_bytes();
    logic [7:0] b;
    i_host.bytes(1'b1, 8'h02, 8'h12, b);
    i_host.bytes(1'b1, 8'h03, 8'h34, b);
    rc(7'h02, 16'h1234);
    i_host.bytes(1'b0, 8'h02, 8'h00, b);
    chk({9'h0, b}, 17'h12);
    i_host.bytes(1'b0, 8'h03, 8'h00, b);
    chk({9'h0, b}, 17'h34);
    i_host.bytes(1'b1, 8'h83, 8'h56, b);
    rc(7'h02, 16'h1234);
    i_host.bytes(1'b0, 8'h82, 8'h00, b);
    chk({9'h0, b}, 17'h00);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clock);
    t_defaults();
    t_volume();
    t_tone();
    t_power();
    t_ext();
    t_rate();
    t_multi();
    t_bytes();
    wr(7'h00, 16'h5a5a);
    settle();
    t_defaults();
    close_out();
  end
endmodule

bind cmrb_bank cmrb_sva i_sva (.clock, .rstn, .req, .byte_wr, .byte_rd, .rdata, .rvalid,
  .left_atten, .right_atten, .link_quiesce, .amp_shutdown_request, .double_rate_en,
  .effective_rate);
`default_nettype wire
